// ==== src/lpi_pkg.sv ====
// Constants, register map and field layouts of the light/proximity interrupt block
package lpi_pkg;

  // Clock rate and ambient integration period
  localparam int unsigned CLK_KHZ    = 40000;
  localparam int unsigned AMB_INT_MS = 100;
  localparam int unsigned AMB_INT_CYC = AMB_INT_MS * CLK_KHZ;

  // Fixed 7-bit serial bus address of the device
  localparam logic [6:0] DEV_ADDR = 7'h44;

  // Register offsets
  localparam logic [3:0] REG_ID       = 4'h0;
  localparam logic [3:0] REG_CFG      = 4'h1;
  localparam logic [3:0] REG_INTC     = 4'h2;
  localparam logic [3:0] REG_NEAR_LO  = 4'h3;
  localparam logic [3:0] REG_NEAR_HI  = 4'h4;
  localparam logic [3:0] REG_AMB_TH1  = 4'h5;
  localparam logic [3:0] REG_AMB_TH2  = 4'h6;
  localparam logic [3:0] REG_AMB_TH3  = 4'h7;
  localparam logic [3:0] REG_NEAR_DAT = 4'h8;
  localparam logic [3:0] REG_AMB_DT1  = 4'h9;
  localparam logic [3:0] REG_AMB_DT2  = 4'ha;
  localparam logic [3:0] REG_TEST1    = 4'he;
  localparam logic [3:0] REG_TEST2    = 4'hf;

  // Reset values
  localparam logic [7:0] RST_CFG     = 8'h00;
  localparam logic [7:0] RST_INTC    = 8'h00;
  localparam logic [7:0] RST_NEAR_LO = 8'h00;
  localparam logic [7:0] RST_NEAR_HI = 8'hff;
  localparam logic [7:0] RST_AMB_TH1 = 8'h00;
  localparam logic [7:0] RST_AMB_TH2 = 8'hf0;
  localparam logic [7:0] RST_AMB_TH3 = 8'hff;
  localparam logic [7:0] RST_TEST    = 8'h00;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam logic [3:0] ZERO_NIB    = 4'h0;

  // Persistency encodings and run lengths
  localparam logic [1:0] PRST_1  = 2'h0;
  localparam logic [1:0] PRST_4  = 2'h1;
  localparam logic [1:0] PRST_8  = 2'h2;
  localparam logic [4:0] RUN_1   = 5'h01;
  localparam logic [4:0] RUN_4   = 5'h04;
  localparam logic [4:0] RUN_8   = 5'h08;
  localparam logic [4:0] RUN_16  = 5'h10;
  localparam logic [4:0] RUN_ONE = 5'h01;

  // Register 1: conversion and front-end control
  typedef struct packed {
    logic       near_conv_on;
    logic [2:0] near_sleep;
    logic       led_drive;
    logic       ambient_conv_on;
    logic       ambient_gain_select;
    logic       light_vs_infrared_select;
  } lpi_cfg_t;

  // Register 2: flags, persistency and combine mode
  typedef struct packed {
    logic       near_object_flag;
    logic [1:0] near_persist_count;
    logic       spare;
    logic       ambient_window_flag;
    logic [1:0] ambient_persist_count;
    logic       flag_combine_select;
  } lpi_intc_t;

  // Run length needed for a persistency code
  function automatic logic [4:0] lpi_run_need(input logic [1:0] code);
    case (code)
      PRST_1:  lpi_run_need = RUN_1;
      PRST_4:  lpi_run_need = RUN_4;
      PRST_8:  lpi_run_need = RUN_8;
      default: lpi_run_need = RUN_16;
    endcase
  endfunction

  // Saturating run counter step
  function automatic logic [4:0] lpi_run_step(input logic [4:0] run, input logic [4:0] need);
    lpi_run_step = (run >= need) ? need : 5'(run + RUN_ONE);
  endfunction

endpackage

// ==== src/lpi_top.sv ====
// Interrupt and control logic of an ambient-light and proximity sensor
//
// What this block does
// RULE_01 Ambient flag sets when ambient count lies outside the low/high window.
// RULE_02 Ambient flag stays set until software writes zero to it.
// RULE_03 Near flag sets after persistency-many consecutive counts above the high limit.
// RULE_04 Near flag clears after persistency-many counts below low limit, or software zero.
// RULE_05 Each channel needs its own consecutive run before the interrupt pin acts.
// RULE_06 Combine bit: 1 ANDs both flags onto the pin, 0 (default) ORs them.
// RULE_07 Ambient window thresholds come from host-written registers 5 to 7.
// RULE_08 Near low and high limits come from registers 3 and 4.
// RULE_09 Ambient current output is high-impedance while ambient conversion is off.
// RULE_10 Host should switch to high gain and re-measure above 1800 counts.
// RULE_11 Host recovery: write recovery sequence, wait about 1 ms, rewrite all.
// RULE_12 Both conversions off, or register 1 all zero, means power-down.
// RULE_13 Gain select, register 1 bit 1, chooses the count scale.
// RULE_14 Ambient conversion integrates over a fixed 100 ms period.
// RULE_15 Device answers only at its fixed 7-bit bus address.
// RULE_16 Thresholds split across byte registers; register 6 packs two nibbles.
// RULE_17 Near comparison uses the 8-bit count readable at register 8.
// RULE_18 Infrared mode uses the same count path and window comparison.
// RULE_19 Interrupt pin returns high once the combined condition no longer holds.
// RULE_20 A failing conversion restarts the persistency run from zero.
`timescale 1ns/1ps
`default_nettype none

module lpi_top
  import lpi_pkg::*;
#(
  parameter int unsigned AMB_INT_CYCLES = AMB_INT_CYC,
  parameter logic [7:0]  DEVICE_ID      = 8'h5a    // Arbitrary identity value
) (
  input  wire logic        I_CLOCK,       // 40 MHz clock
  input  wire logic        I_RST_N,       // Asynchronous reset, active low
  input  wire logic [6:0]  I_BUS_ADDR,    // Bus address of the current access
  input  wire logic [3:0]  I_REG_ADDR,    // Register offset
  input  wire logic [7:0]  I_WDATA,       // Write data
  input  wire logic        I_WR,          // Write strobe
  input  wire logic        I_RD,          // Read strobe
  output logic      [7:0]  O_RDATA,       // Read data, cycle after strobe
  input  wire logic [11:0] I_AMB_COUNT,   // Ambient converter result
  input  wire logic        I_AMB_TOGGLE,  // Toggles per ambient result
  input  wire logic [7:0]  I_NEAR_COUNT,  // Proximity converter result
  input  wire logic        I_NEAR_TOGGLE, // Toggles per proximity result
  output logic             O_INT_N,       // Interrupt pin, active low
  output logic             O_AMB_SAMPLE,  // Pulse: ambient integration done
  output logic      [11:0] O_IALS_CODE,   // Code for ambient current output
  output logic             O_IALS_OE,     // Ambient current output enable
  output logic             O_AMB_ON,      // Ambient converter running
  output logic             O_NEAR_ON,     // Proximity converter running
  output logic             O_GAIN,        // Ambient gain select
  output logic             O_IR_MODE,     // Infrared measuring mode
  output logic             O_LED_DRIVE,   // LED sink current select
  output logic      [2:0]  O_NEAR_SLEEP,  // Proximity sleep code
  output logic             O_POWER_DOWN   // Power-down state
);

  logic        rst_s1;
  logic        rst_n;
  lpi_cfg_t    cfg;
  lpi_intc_t   intc;
  logic [7:0]  near_lo;
  logic [7:0]  near_hi;
  logic [7:0]  amb_th1;
  logic [7:0]  amb_th2;
  logic [7:0]  amb_th3;
  logic [7:0]  test1;
  logic [7:0]  test2;
  logic [11:0] amb_data;
  logic [7:0]  near_data;
  logic [1:0]  tog_s1;
  logic [1:0]  tog_s2;
  logic [1:0]  tog_s3;
  logic [1:0]  tog_acc;
  logic        amb_evt;
  logic        near_evt;
  logic [4:0]  amb_run;
  logic [4:0]  hi_run;
  logic [4:0]  lo_run;
  logic [31:0] int_cnt;
  logic        sel;
  logic        wr_intc;
  lpi_intc_t   wr_val;
  logic [11:0] amb_lo;
  logic [11:0] amb_hi;
  logic        amb_out;
  logic        near_above;
  logic        near_below;
  logic        amb_set;
  logic        near_set;
  logic        near_clr;
  logic [4:0]  amb_need;
  logic [4:0]  near_need;

  // Assertions below run on the block clock and the internal reset copy
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!rst_n);

  // Reset release through two flip-flops
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Access decode and comparisons
  assign sel        = (I_BUS_ADDR == DEV_ADDR);                          // RULE_15
  assign wr_intc    = sel && I_WR && (I_REG_ADDR == REG_INTC);
  assign wr_val     = lpi_intc_t'(I_WDATA);
  assign amb_lo     = {amb_th2[3:0], amb_th1};                           // RULE_07 RULE_16
  assign amb_hi     = {amb_th3, amb_th2[7:4]};                           // RULE_07 RULE_16
  assign amb_out    = (I_AMB_COUNT < amb_lo) || (I_AMB_COUNT > amb_hi);  // RULE_01 RULE_18
  assign near_above = (I_NEAR_COUNT > near_hi);                          // RULE_08
  assign near_below = (I_NEAR_COUNT < near_lo);                          // RULE_08
  assign amb_need   = lpi_run_need(intc.ambient_persist_count);          // RULE_05
  assign near_need  = lpi_run_need(intc.near_persist_count);             // RULE_05
  assign amb_set    = amb_evt && amb_out && (lpi_run_step(amb_run, amb_need) >= amb_need);
  assign near_set   = near_evt && near_above && (lpi_run_step(hi_run, near_need) >= near_need);
  assign near_clr   = near_evt && near_below && (lpi_run_step(lo_run, near_need) >= near_need);

  // Software-written configuration registers
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cfg     <= lpi_cfg_t'(RST_CFG);
      near_lo <= RST_NEAR_LO;
      near_hi <= RST_NEAR_HI;
      amb_th1 <= RST_AMB_TH1;
      amb_th2 <= RST_AMB_TH2;
      amb_th3 <= RST_AMB_TH3;
      test1   <= RST_TEST;
      test2   <= RST_TEST;
    end else if (sel && I_WR) begin                                      // RULE_15
      case (I_REG_ADDR)
        REG_CFG:     cfg     <= lpi_cfg_t'(I_WDATA);                     // RULE_12
        REG_NEAR_LO: near_lo <= I_WDATA;                                 // RULE_08
        REG_NEAR_HI: near_hi <= I_WDATA;                                 // RULE_08
        REG_AMB_TH1: amb_th1 <= I_WDATA;                                 // RULE_07
        REG_AMB_TH2: amb_th2 <= I_WDATA;                                 // RULE_16
        REG_AMB_TH3: amb_th3 <= I_WDATA;                                 // RULE_07
        REG_TEST1:   test1   <= I_WDATA;
        REG_TEST2:   test2   <= I_WDATA;
        default:     cfg     <= cfg;
      endcase
    end
  end

  // Interrupt control register; hardware set wins over software clear
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      intc <= lpi_intc_t'(RST_INTC);
    end else begin
      if (wr_intc) begin
        intc.near_persist_count    <= wr_val.near_persist_count;
        intc.ambient_persist_count <= wr_val.ambient_persist_count;
        intc.flag_combine_select   <= wr_val.flag_combine_select;    // RULE_06
        intc.spare                 <= wr_val.spare;
      end
      if (amb_set) begin
        intc.ambient_window_flag <= 1'b1;                            // RULE_01
      end else if (wr_intc && !wr_val.ambient_window_flag) begin
        intc.ambient_window_flag <= 1'b0;                            // RULE_02
      end
      if (near_set) begin
        intc.near_object_flag <= 1'b1;                               // RULE_03
      end else if (near_clr || (wr_intc && !wr_val.near_object_flag)) begin
        intc.near_object_flag <= 1'b0;                               // RULE_04
      end
    end
  end

  // Result toggles cross in through three flops; a change counts when stages two and three agree
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1  <= 2'h0;
      tog_s2  <= 2'h0;
      tog_s3  <= 2'h0;
      tog_acc <= 2'h0;
    end else begin
      tog_s1  <= {I_NEAR_TOGGLE, I_AMB_TOGGLE};
      tog_s2  <= tog_s1;
      tog_s3  <= tog_s2;
      tog_acc <= (tog_s2 == tog_s3) ? tog_s3 : tog_acc;
    end
  end
  // Results are taken only while the matching converter is on
  assign amb_evt  = (tog_s2[0] == tog_s3[0]) && (tog_s3[0] != tog_acc[0]) && cfg.ambient_conv_on;
  assign near_evt = (tog_s2[1] == tog_s3[1]) && (tog_s3[1] != tog_acc[1]) && cfg.near_conv_on;

  // Latest conversion results
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      amb_data  <= 12'h000;
      near_data <= 8'h00;
    end else begin
      if (amb_evt) begin
        amb_data <= I_AMB_COUNT;                                     // RULE_18
      end
      if (near_evt) begin
        near_data <= I_NEAR_COUNT;                                   // RULE_17
      end
    end
  end

  // Persistency runs; a failing result restarts the run
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      amb_run <= 5'h00;
      hi_run  <= 5'h00;
      lo_run  <= 5'h00;
    end else begin
      if (amb_evt) begin
        amb_run <= amb_out ? lpi_run_step(amb_run, amb_need) : 5'h00;      // RULE_05 RULE_20
      end
      if (near_evt) begin
        hi_run <= near_above ? lpi_run_step(hi_run, near_need) : 5'h00;    // RULE_05 RULE_20
        lo_run <= near_below ? lpi_run_step(lo_run, near_need) : 5'h00;    // RULE_20
      end
    end
  end

  // Fixed ambient integration period
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt      <= 32'h0;
      O_AMB_SAMPLE <= 1'b0;
    end else if (!cfg.ambient_conv_on) begin
      int_cnt      <= 32'h0;
      O_AMB_SAMPLE <= 1'b0;
    end else begin
      O_AMB_SAMPLE <= (int_cnt == AMB_INT_CYCLES - 1);               // RULE_14
      int_cnt      <= (int_cnt == AMB_INT_CYCLES - 1) ? 32'h0 : int_cnt + 32'h1;
    end
  end

  // Interrupt pin from the combined flags
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_INT_N <= 1'b1;
    end else if (intc.flag_combine_select) begin
      O_INT_N <= !(intc.ambient_window_flag && intc.near_object_flag);  // RULE_06 RULE_19
    end else begin
      O_INT_N <= !(intc.ambient_window_flag || intc.near_object_flag);  // RULE_06 RULE_19
    end
  end

  // Front-end control outputs
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_IALS_CODE  <= 12'h000;
      O_IALS_OE    <= 1'b0;
      O_AMB_ON     <= 1'b0;
      O_NEAR_ON    <= 1'b0;
      O_GAIN       <= 1'b0;
      O_IR_MODE    <= 1'b0;
      O_LED_DRIVE  <= 1'b0;
      O_NEAR_SLEEP <= 3'h0;
      O_POWER_DOWN <= 1'b1;
    end else begin
      O_IALS_OE    <= cfg.ambient_conv_on;                              // RULE_09
      O_IALS_CODE  <= cfg.ambient_conv_on ? amb_data : 12'h000;         // RULE_09
      O_AMB_ON     <= cfg.ambient_conv_on;
      O_NEAR_ON    <= cfg.near_conv_on;
      O_GAIN       <= cfg.ambient_gain_select;                          // RULE_13
      O_IR_MODE    <= cfg.light_vs_infrared_select;                     // RULE_18
      O_LED_DRIVE  <= cfg.led_drive;
      O_NEAR_SLEEP <= cfg.near_sleep;
      O_POWER_DOWN <= !cfg.ambient_conv_on && !cfg.near_conv_on;        // RULE_12
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      O_RDATA <= ZERO_BYTE;
    end else if (sel && I_RD) begin                                  // RULE_15
      case (I_REG_ADDR)
        REG_ID:       O_RDATA <= DEVICE_ID;
        REG_CFG:      O_RDATA <= cfg;
        REG_INTC:     O_RDATA <= intc;
        REG_NEAR_LO:  O_RDATA <= near_lo;
        REG_NEAR_HI:  O_RDATA <= near_hi;
        REG_AMB_TH1:  O_RDATA <= amb_th1;
        REG_AMB_TH2:  O_RDATA <= amb_th2;
        REG_AMB_TH3:  O_RDATA <= amb_th3;
        REG_NEAR_DAT: O_RDATA <= near_data;                          // RULE_17
        REG_AMB_DT1:  O_RDATA <= amb_data[7:0];
        REG_AMB_DT2:  O_RDATA <= {ZERO_NIB, amb_data[11:8]};
        REG_TEST1:    O_RDATA <= test1;
        REG_TEST2:    O_RDATA <= test2;
        default:      O_RDATA <= ZERO_BYTE;
      endcase
    end else begin
      O_RDATA <= ZERO_BYTE;
    end
  end

  // Checks on flag, pin and control behaviour
  a_amb_flag_set: assert property (amb_evt && amb_out && amb_run + RUN_ONE >= amb_need |=> intc.ambient_window_flag) // RULE_01
    else $error("ambient flag not set on qualifying run");
  a_amb_flag_hold: assert property (intc.ambient_window_flag && !wr_intc |=> intc.ambient_window_flag) // RULE_02
    else $error("ambient flag cleared without software write");
  a_near_set_cause: assert property ($rose(intc.near_object_flag) |-> $past(near_evt && near_above)) // RULE_03
    else $error("near flag set without count above high limit");
  a_near_clr_cause: assert property ($fell(intc.near_object_flag) |-> $past(near_clr || wr_intc)) // RULE_04
    else $error("near flag cleared without cause");
  a_run_restart: assert property (near_evt && !near_above |=> hi_run == 5'h00) // RULE_20
    else $error("persistency run not restarted");
  a_amb_run_need: assert property (amb_evt && amb_out && amb_run + RUN_ONE < amb_need // RULE_05
                                   && !intc.ambient_window_flag |=> !intc.ambient_window_flag)
    else $error("ambient flag set before run complete");
  a_pin_or_mode: assert property (!intc.flag_combine_select && intc.near_object_flag ##1 // RULE_06
                                  !intc.flag_combine_select |-> !O_INT_N)
    else $error("pin not asserted in either-flag mode");
  a_pin_release: assert property (intc.flag_combine_select && !intc.near_object_flag ##1 // RULE_19
                                  intc.flag_combine_select |-> O_INT_N)
    else $error("pin held low without both flags");
  a_ials_hiz: assert property (!cfg.ambient_conv_on |=> !O_IALS_OE && O_IALS_CODE == 12'h000) // RULE_09
    else $error("ambient current output driven while off");
  a_power_down: assert property (I_WR && sel && I_REG_ADDR == REG_CFG && I_WDATA == ZERO_BYTE |=> ##1 O_POWER_DOWN) // RULE_12
    else $error("power-down not entered");
  a_foreign_addr: assert property (I_WR && !sel |=> $stable(cfg) && $stable(near_hi)) // RULE_15
    else $error("write to foreign address took effect");
  a_gain_follow: assert property ($changed(cfg.ambient_gain_select) |=> O_GAIN == cfg.ambient_gain_select) // RULE_13
    else $error("gain output not following register");

  c_amb_flag: cover property ($rose(intc.ambient_window_flag));
  c_near_clear: cover property ($fell(intc.near_object_flag) && !$past(wr_intc));
  c_and_pin: cover property (intc.flag_combine_select && $fell(O_INT_N));
  c_amb_sample: cover property (O_AMB_SAMPLE);

endmodule

`default_nettype wire

// ==== verif/lpi_conv_model.sv ====
// Converter-side model: delivers ambient and proximity results on the link clock
`timescale 1ns/1ps
`default_nettype none

module lpi_conv_model (
  input  wire logic        i_link_clk,    // Converter clock, 200 ns
  input  wire logic [11:0] i_amb_val,     // Ambient value to deliver next
  input  wire logic        i_amb_req,     // Toggled by the bench per ambient result
  input  wire logic [7:0]  i_near_val,    // Proximity value to deliver next
  input  wire logic        i_near_req,    // Toggled by the bench per proximity result
  output logic      [11:0] o_amb_count,   // Ambient result
  output logic             o_amb_toggle,  // Toggles per ambient result
  output logic      [7:0]  o_near_count,  // Proximity result
  output logic             o_near_toggle  // Toggles per proximity result
);
  logic [1:0] amb_age;
  logic [1:0] near_age;

  // Idle values at time zero
  initial begin
    o_amb_count   = 12'h000;
    o_amb_toggle  = 1'b0;
    o_near_count  = 8'h00;
    o_near_toggle = 1'b0;
    amb_age       = 2'h0;
    near_age      = 2'h0;
  end

  // Result holds two link cycles, then is scrambled so stale data is never trusted
  always @(posedge i_link_clk) begin
    if (i_amb_req != o_amb_toggle) begin
      o_amb_count  <= i_amb_val;
      o_amb_toggle <= i_amb_req;
      amb_age      <= 2'h2;
    end else if (amb_age != 2'h0) begin
      amb_age <= amb_age - 2'h1;
      if (amb_age == 2'h1) begin
        o_amb_count <= ~o_amb_count;
      end
    end
  end

  // Same handshake for the proximity channel
  always @(posedge i_link_clk) begin
    if (i_near_req != o_near_toggle) begin
      o_near_count  <= i_near_val;
      o_near_toggle <= i_near_req;
      near_age      <= 2'h2;
    end else if (near_age != 2'h0) begin
      near_age <= near_age - 2'h1;
      if (near_age == 2'h1) begin
        o_near_count <= ~o_near_count;
      end
    end
  end
endmodule

`default_nettype wire

// ==== verif/lpi_top_bench.sv ====
// Self-checking bench for the light/proximity interrupt block
`timescale 1ns/1ps
`default_nettype none

module lpi_top_bench
  import lpi_pkg::*;
;
  localparam logic [7:0] ID = 8'h5a; // Arbitrary identity value
  logic        clk;
  logic        lk;
  logic        rst_n;
  logic [6:0]  bus;
  logic [3:0]  ra;
  logic [7:0]  wd;
  logic        wr;
  logic        rd;
  logic [11:0] av;
  logic        areq;
  logic [7:0]  nv;
  logic        nreq;
  wire logic [7:0]  rdata;
  wire logic [11:0] acnt, code;
  wire logic [7:0]  ncnt;
  wire logic        atog, ntog, int_n, smp, oe, amb_on, near_on, gain, ir, led, pd;
  wire logic [2:0]  sleep;
  int          err_total = 0;
  int          compares = 0;
  logic [7:0]  rv [16] = '{ID, RST_CFG, RST_INTC, RST_NEAR_LO, RST_NEAR_HI, RST_AMB_TH1, RST_AMB_TH2,
                           RST_AMB_TH3, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, RST_TEST, RST_TEST};

  // Main clock 40 MHz and unrelated 200 ns converter clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    lk = 1'b0;
    forever #100 lk = ~lk;
  end

  lpi_top #(.AMB_INT_CYCLES(20), .DEVICE_ID(ID)) DUT (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_BUS_ADDR(bus), .I_REG_ADDR(ra), .I_WDATA(wd), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_AMB_COUNT(acnt), .I_AMB_TOGGLE(atog), .I_NEAR_COUNT(ncnt),
    .I_NEAR_TOGGLE(ntog), .O_INT_N(int_n), .O_AMB_SAMPLE(smp), .O_IALS_CODE(code), .O_IALS_OE(oe),
    .O_AMB_ON(amb_on), .O_NEAR_ON(near_on), .O_GAIN(gain), .O_IR_MODE(ir), .O_LED_DRIVE(led),
    .O_NEAR_SLEEP(sleep), .O_POWER_DOWN(pd));

  lpi_conv_model conv (.i_link_clk(lk), .i_amb_val(av), .i_amb_req(areq), .i_near_val(nv), .i_near_req(nreq),
    .o_amb_count(acnt), .o_amb_toggle(atog), .o_near_count(ncnt), .o_near_toggle(ntog));

  // Verdict and end of run
  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Compare one value, four-state exact
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic wreg(input logic [3:0] a, input logic [7:0] d, input logic [6:0] b = DEV_ADDR);
    @(posedge clk);
    bus <= b;
    ra  <= a;
    wd  <= d;
    wr  <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; data looked at in the following cycle only
  task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [6:0] b = DEV_ADDR);
    @(posedge clk);
    bus <= b;
    ra  <= a;
    rd  <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", {4'h0, e}, {4'h0, rdata});
  endtask

  // One ambient result; the wait covers sync, persistency, flag and pin update
  task automatic amb(input logic [11:0] v);
    @(posedge clk);
    av   <= v;
    areq <= ~areq;
    repeat (80) @(posedge clk);
  endtask

  // One proximity result, same spacing
  task automatic near(input logic [7:0] v);
    @(posedge clk);
    nv   <= v;
    nreq <= ~nreq;
    repeat (80) @(posedge clk);
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    $display("mismatch watchdog expected done seen running");
    end_sim();
  end

  // Main sequence
  initial begin
    int n;
    rst_n = 1'b0;
    bus   = DEV_ADDR;
    ra    = 4'h0;
    wd    = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
    av    = 12'h000;
    areq  = 1'b0;
    nv    = 8'h00;
    nreq  = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("int_n", 12'h1, 12'(int_n));
    chk("pd", 12'h1, 12'(pd));
    // Reset values, unmapped offsets read zero
    for (int i = 0; i < 16; i++) rreg(4'(i), rv[i]);
    // Foreign bus address and read-only data are refused
    wreg(REG_TEST1, 8'h33, 7'h45);
    rreg(REG_TEST1, 8'h00);
    wreg(REG_TEST1, 8'h33);
    rreg(REG_TEST1, 8'h00, 7'h45);
    rreg(REG_TEST1, 8'h33);
    wreg(REG_NEAR_DAT, 8'h77);
    rreg(REG_NEAR_DAT, 8'h00);
    // Recovery sequence, then wait 1 ms
    wreg(REG_CFG, 8'h00);
    wreg(REG_TEST2, 8'h29);
    wreg(REG_TEST1, 8'h00);
    wreg(REG_TEST2, 8'h00);
    repeat (40000) @(posedge clk);
    // Config fields reach the front-end outputs
    wreg(REG_CFG, 8'hbb);
    repeat (2) @(posedge clk);
    #1;
    chk("cfg", 12'h0bb, {4'h0, near_on, sleep, led, amb_on, gain, ir});
    chk("pd_oe", 12'h0, {10'h0, pd, oe});
    wreg(REG_CFG, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("pd", 12'h1, 12'(pd));
    // Ambient window low 0x100 high 0x800, persistency 4
    wreg(REG_AMB_TH1, 8'h00);
    wreg(REG_AMB_TH2, 8'h01);
    wreg(REG_AMB_TH3, 8'h80);
    wreg(REG_INTC, 8'h02);
    wreg(REG_CFG, 8'h04);
    amb(12'h400);
    rreg(REG_AMB_DT1, 8'h00);
    rreg(REG_AMB_DT2, 8'h04);
    chk("ials_oe", 12'h1, 12'(oe));
    chk("ials", 12'h400, code);
    repeat (3) amb(12'h900);
    amb(12'h800);
    repeat (3) amb(12'h900);
    rreg(REG_INTC, 8'h02);
    chk("int_n", 12'h1, 12'(int_n));
    amb(12'h900);
    rreg(REG_INTC, 8'h0a);
    chk("int_n", 12'h0, 12'(int_n));
    // Host raises gain once a count above 1800 is seen
    rreg(REG_AMB_DT2, 8'h09);
    wreg(REG_CFG, 8'h06);
    repeat (2) @(posedge clk);
    #1;
    chk("gain", 12'h1, 12'(gain));
    amb(12'h400);
    rreg(REG_INTC, 8'h0a);
    wreg(REG_INTC, 8'h02);
    rreg(REG_INTC, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    chk("int_n", 12'h1, 12'(int_n));
    wreg(REG_INTC, 8'h00);
    amb(12'h0ff);
    rreg(REG_INTC, 8'h08);
    // Integration pulses while ambient is on
    n = 0;
    repeat (200) begin
      @(posedge clk);
      #1 if (smp === 1'b1) n++;
    end
    chk("amb_sample", 12'd10, 12'(n));
    wreg(REG_INTC, 8'h00);
    wreg(REG_CFG, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("ials_off", 12'h0, code);
    chk("oe_off", 12'h0, 12'(oe));
    // Near hysteresis low 0x20 high 0xc0, persistency 8
    wreg(REG_NEAR_LO, 8'h20);
    wreg(REG_NEAR_HI, 8'hc0);
    wreg(REG_INTC, 8'h40);
    wreg(REG_CFG, 8'h80);
    repeat (7) near(8'hd0);
    rreg(REG_INTC, 8'h40);
    near(8'hd0);
    rreg(REG_NEAR_DAT, 8'hd0);
    rreg(REG_INTC, 8'hc0);
    chk("int_n", 12'h0, 12'(int_n));
    repeat (7) near(8'h10);
    rreg(REG_INTC, 8'hc0);
    near(8'h10);
    rreg(REG_INTC, 8'h40);
    chk("int_n", 12'h1, 12'(int_n));
    wreg(REG_INTC, 8'h00);
    near(8'hd0);
    rreg(REG_INTC, 8'h80);
    wreg(REG_INTC, 8'h00);
    rreg(REG_INTC, 8'h00);
    // AND combine needs both flags; ambient runs in infrared mode here
    wreg(REG_CFG, 8'h85);
    wreg(REG_INTC, 8'h01);
    amb(12'h900);
    rreg(REG_INTC, 8'h09);
    chk("int_n", 12'h1, 12'(int_n));
    near(8'hd0);
    rreg(REG_INTC, 8'h89);
    chk("int_n", 12'h0, 12'(int_n));
    near(8'h10);
    rreg(REG_INTC, 8'h09);
    chk("int_n", 12'h1, 12'(int_n));
    end_sim();
  end
endmodule

`default_nettype wire
